// >>> hw/decim_pkg.sv
/*
 * Shared constants for the decimation chain and its receiver:
 * register offsets, field positions, reset values, widths.
 * Assumes an 8-bit register space reached through the chain's carrier.
 */
package decim_pkg;
    localparam int SAMPLE_W = 14;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PRI_STAGES = 9;
    localparam int QUAD_STAGES = 8;
    localparam int RATE_W = 4;
    localparam int PHASE_W = 3;

    localparam logic [7:0] ADDR_OUTPUT_RATE = 8'h02;
    localparam logic [7:0] ADDR_CLK_PHASE = 8'h64;
    localparam logic [7:0] ADDR_PRI_LOW = 8'h7a;
    localparam logic [7:0] ADDR_PRI_HIGH = 8'h7b;
    localparam logic [7:0] ADDR_QUAD = 8'h7c;
    localparam logic [7:0] ADDR_POST_OPTS = 8'h7d;
    localparam logic [7:0] ADDR_STATUS = 8'h7e;

    // Output rate register: data-rate divider low nibble, clock-rate high
    localparam int DATARATE_LSB = 0;
    localparam int CLKRATE_LSB = 4;
    // Phase register: select in bits 2:0, enable in bit 3
    localparam int PHASE_LSB = 0;
    localparam int PHASE_EN_BIT = 3;
    // Post-processing options register
    localparam int OPT_GAIN_BIT = 0;
    localparam int OPT_DOWNCONV_BIT = 1;

    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // Phase select mask at 2x: only four phases
    localparam logic [2:0] PHASE_MASK_2X = 3'h3;
    localparam logic [3:0] RATE_2X = 4'h1;
    localparam logic [3:0] RATE_1X = 4'h0;
endpackage : decim_pkg

// >>> hw/decim_if.sv
/*
 * Carrier between the decimation chain and the downstream receiver.
 * Assumes both ends run on mclk; the chain owns the data clock strobe.
 */
`timescale 1ns/1ps
interface decim_if;
    import decim_pkg::*;
    logic [ADDR_W-1:0] cfg_addr;
    logic [DATA_W-1:0] cfg_wdata;
    logic cfg_wr;
    logic cfg_rd;
    logic [DATA_W-1:0] cfg_rdata;
    logic [SAMPLE_W-1:0] i_data;
    logic [SAMPLE_W-1:0] q_data;
    logic q_valid;
    logic output_data_clock;
    logic data_valid;

    modport chain (
        input cfg_addr, cfg_wdata, cfg_wr, cfg_rd,
        output cfg_rdata, i_data, q_data, q_valid, output_data_clock, data_valid
    );
    modport receiver (
        output cfg_addr, cfg_wdata, cfg_wr, cfg_rd,
        input cfg_rdata, i_data, q_data, q_valid, output_data_clock, data_valid
    );
endinterface : decim_if

// >>> hw/halving_stage.sv
/*
 * One halving stage: 3-tap [1 2 1]/4 low-pass, keeps every second sample.
 * Assumes in_valid pulses at most every cycle; bypass passes data through.
 */
`timescale 1ns/1ps
module halving_stage #(
    parameter int W = 14
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic enable,
    input wire logic in_valid,
    input wire logic signed [W-1:0] in_data,
    output logic out_valid,
    output logic signed [W-1:0] out_data
);
    logic signed [W-1:0] tap1_ff;
    logic signed [W-1:0] tap2_ff;
    logic phase_ff;
    logic signed [W+1:0] acc;

    assign acc = (W+2)'(in_data) + ((W+2)'(tap1_ff) <<< 1) + (W+2)'(tap2_ff);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tap1_ff <= '0;
            tap2_ff <= '0;
            phase_ff <= 1'b0;
        end else if (in_valid) begin
            tap1_ff <= in_data;
            tap2_ff <= tap1_ff;
            phase_ff <= enable ? ~phase_ff : 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            out_valid <= in_valid && (!enable || phase_ff);
            out_data <= enable ? acc[W+1:2] : in_data;
        end
    end
endmodule : halving_stage

// >>> hw/decim_chain.sv
/*
 * Decimation chain end: register file, pre-processing, primary and
 * quadrature halving cascades, output data clock divider with phase delay.
 * Assumes samples arrive on mclk with adc_valid, one per sampling clock.
 */
//
// Contract
// - Primary chain up to 512x, nine stages.
// - Each stage halves its input rate.
// - Without down-conversion, quadrature chain idle.
// - Configurer sets both chains equal with down-conversion.
// - Configurer clears primary first stage with down-conversion.
// - Quadrature chain filters Q by own field.
// - Half-band 2x plus 256x per chain.
// - Gain/offset and mixing precede decimation.
// - Each option enabled by own bit.
// - Output clock divided by decimation rate.
// - Configurer sets data and clock rate fields.
// - Configurer rewrites rates on decimation change.
// - Phase enable bit and 3-bit phase select.
// - Four phases at 2x, eight otherwise.
// - Phase control only when clock divided.
`timescale 1ns/1ps
module decim_chain
    import decim_pkg::*;
#(
    parameter int NPRI = PRI_STAGES,
    parameter int NQUAD = QUAD_STAGES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic adc_valid,
    input wire logic signed [SAMPLE_W-1:0] adc_data,
    input wire logic signed [SAMPLE_W-1:0] gain_offset,
    decim_if.chain bus
);
    logic [7:0] rate_ff;
    logic [7:0] phase_ff;
    logic [7:0] pri_low_ff;
    logic [7:0] pri_high_ff;
    logic [7:0] quad_ff;
    logic [7:0] opts_ff;

    // Register writes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rate_ff <= RESET_VAL;
            phase_ff <= RESET_VAL;
            pri_low_ff <= RESET_VAL;
            pri_high_ff <= RESET_VAL;
            quad_ff <= RESET_VAL;
            opts_ff <= RESET_VAL;
        end else if (bus.cfg_wr) begin
            case (bus.cfg_addr)
                ADDR_OUTPUT_RATE: rate_ff <= bus.cfg_wdata;
                ADDR_CLK_PHASE: phase_ff <= bus.cfg_wdata;
                ADDR_PRI_LOW: pri_low_ff <= bus.cfg_wdata;
                ADDR_PRI_HIGH: pri_high_ff <= bus.cfg_wdata;
                ADDR_QUAD: quad_ff <= bus.cfg_wdata;
                ADDR_POST_OPTS: opts_ff <= bus.cfg_wdata;
                default: ;
            endcase
        end
    end

    logic [NPRI-1:0] pri_sel;
    logic [NQUAD-1:0] quad_sel;
    logic gain_en;
    logic downconv_en;
    assign pri_sel = NPRI'({pri_high_ff, pri_low_ff});
    assign quad_sel = NQUAD'(quad_ff);
    assign gain_en = opts_ff[OPT_GAIN_BIT];
    assign downconv_en = opts_ff[OPT_DOWNCONV_BIT];

    // Pre-processing: gain/offset then fs/4 mixer and 2x half-band
    logic signed [SAMPLE_W-1:0] pre_s;
    logic [1:0] nco_ff;
    logic signed [SAMPLE_W-1:0] mix_i_ff;
    logic signed [SAMPLE_W-1:0] mix_q_ff;
    logic mix_v_ff;
    logic hb_ph_ff;
    logic signed [SAMPLE_W-1:0] hb_i_ff;
    logic signed [SAMPLE_W-1:0] hb_q_ff;
    logic hb_v_ff;

    assign pre_s = gain_en ? adc_data + gain_offset : adc_data;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            nco_ff <= 2'h0;
            mix_i_ff <= '0;
            mix_q_ff <= '0;
            mix_v_ff <= 1'b0;
        end else begin
            mix_v_ff <= adc_valid;
            if (adc_valid) begin
                nco_ff <= downconv_en ? nco_ff + 2'h1 : 2'h0;
                mix_i_ff <= (!downconv_en || !nco_ff[0]) ? (nco_ff[1] ? -pre_s : pre_s) : '0;
                mix_q_ff <= (downconv_en && nco_ff[0]) ? (nco_ff[1] ? pre_s : -pre_s) : '0;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hb_ph_ff <= 1'b0;
            hb_i_ff <= '0;
            hb_q_ff <= '0;
            hb_v_ff <= 1'b0;
        end else begin
            hb_v_ff <= mix_v_ff && (!downconv_en || hb_ph_ff);
            if (mix_v_ff) begin
                hb_ph_ff <= downconv_en ? ~hb_ph_ff : 1'b0;
                hb_i_ff <= mix_i_ff;
                hb_q_ff <= mix_q_ff;
            end
        end
    end

    // Cascades of halving stages
    logic signed [SAMPLE_W-1:0] pd [NPRI+1];
    logic pv [NPRI+1];
    logic signed [SAMPLE_W-1:0] qd [NQUAD+1];
    logic qv [NQUAD+1];
    assign pd[0] = hb_i_ff;
    assign pv[0] = hb_v_ff;
    assign qd[0] = hb_q_ff;
    assign qv[0] = hb_v_ff && downconv_en;

    genvar g;
    generate
        for (g = 0; g < NPRI; g++) begin : g_pri
            halving_stage #(.W(SAMPLE_W)) i_halving_stage (
                .mclk(mclk),
                .rst(rst),
                .enable(pri_sel[g]),
                .in_valid(pv[g]),
                .in_data(pd[g]),
                .out_valid(pv[g+1]),
                .out_data(pd[g+1])
            );
        end
        for (g = 0; g < NQUAD; g++) begin : g_quad
            halving_stage #(.W(SAMPLE_W)) i_halving_stage (
                .mclk(mclk),
                .rst(rst),
                .enable(quad_sel[g] && downconv_en),
                .in_valid(qv[g]),
                .in_data(qd[g]),
                .out_valid(qv[g+1]),
                .out_data(qd[g+1])
            );
        end
    endgenerate

    // Output data and clock: divider counts mclk by 2^clock_rate_divider
    logic [RATE_W-1:0] clk_rate;
    logic [RATE_W-1:0] data_rate;
    logic [15:0] div_cnt_ff;
    logic [15:0] div_len;
    logic [2:0] phase_sel;
    logic phase_on;
    logic [15:0] phase_pos;
    assign clk_rate = rate_ff[CLKRATE_LSB +: RATE_W];
    assign data_rate = rate_ff[DATARATE_LSB +: RATE_W];
    assign div_len = 16'h1 << clk_rate;
    assign phase_on = phase_ff[PHASE_EN_BIT] && (clk_rate != RATE_1X);
    assign phase_sel = (clk_rate == RATE_2X) ? (phase_ff[PHASE_LSB +: PHASE_W] & PHASE_MASK_2X)
                                              : phase_ff[PHASE_LSB +: PHASE_W];
    // Phase step is one eighth of the divided period, at least one cycle;
    // wrapped into the period so short periods never lose the clock
    logic [15:0] phase_raw;
    assign phase_raw = ((div_len >> 3) == 16'h0) ? {13'h0, phase_sel} : 16'(phase_sel) * (div_len >> 3);
    assign phase_pos = phase_on ? (phase_raw & (div_len - 16'h1)) : 16'h0;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_cnt_ff <= 16'h0;
        end else begin
            div_cnt_ff <= (div_cnt_ff + 16'h1 >= div_len) ? 16'h0 : div_cnt_ff + 16'h1;
        end
    end

    logic [15:0] rel_pos;
    assign rel_pos = (div_cnt_ff >= phase_pos) ? div_cnt_ff - phase_pos : div_cnt_ff + div_len - phase_pos;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus.output_data_clock <= 1'b0;
        end else begin
            bus.output_data_clock <= (clk_rate == RATE_1X) ? ~bus.output_data_clock
                                                            : (rel_pos < (div_len >> 1));
        end
    end

    // Data outputs held until the next decimated sample
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus.i_data <= '0;
            bus.q_data <= '0;
            bus.data_valid <= 1'b0;
            bus.q_valid <= 1'b0;
        end else begin
            bus.data_valid <= pv[NPRI];
            bus.q_valid <= qv[NQUAD];
            if (pv[NPRI]) begin
                bus.i_data <= pd[NPRI];
            end
            if (qv[NQUAD]) begin
                bus.q_data <= qd[NQUAD];
            end
        end
    end

    // Register reads answer in the strobe cycle; the receiver registers them.
    // Status shows data-rate match to clock-rate
    always_comb begin
        bus.cfg_rdata = READ_ZERO;
        if (bus.cfg_rd) begin
            case (bus.cfg_addr)
                ADDR_OUTPUT_RATE: bus.cfg_rdata = rate_ff;
                ADDR_CLK_PHASE: bus.cfg_rdata = phase_ff;
                ADDR_PRI_LOW: bus.cfg_rdata = pri_low_ff;
                ADDR_PRI_HIGH: bus.cfg_rdata = pri_high_ff;
                ADDR_QUAD: bus.cfg_rdata = quad_ff;
                ADDR_POST_OPTS: bus.cfg_rdata = opts_ff;
                ADDR_STATUS: bus.cfg_rdata = {6'h0, phase_on, data_rate == clk_rate};
                default: bus.cfg_rdata = READ_ZERO;
            endcase
        end
    end
endmodule : decim_chain

// >>> hw/decim_receiver.sv
/*
 * Receiver end: passes software register accesses to the chain and
 * captures decimated samples on the rising edge of the output data clock.
 * Assumes the chain shares mclk; the data clock is sampled as a level.
 */
`timescale 1ns/1ps
module decim_receiver
    import decim_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] sw_addr,
    input wire logic [DATA_W-1:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [DATA_W-1:0] sw_rdata,
    output logic [SAMPLE_W-1:0] cap_i,
    output logic [SAMPLE_W-1:0] cap_q,
    output logic cap_strobe,
    decim_if.receiver bus
);
    logic out_clk_d_ff;

    // Software drives rate, chain and phase fields in its own cycle
    assign bus.cfg_addr = sw_addr;
    assign bus.cfg_wdata = sw_wdata;
    assign bus.cfg_wr = sw_wr;
    assign bus.cfg_rd = sw_rd;

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sw_rdata <= '0;
        end else begin
            sw_rdata <= bus.cfg_rd ? bus.cfg_rdata : '0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_clk_d_ff <= 1'b0;
            cap_i <= '0;
            cap_q <= '0;
            cap_strobe <= 1'b0;
        end else begin
            out_clk_d_ff <= bus.output_data_clock;
            cap_strobe <= bus.output_data_clock && !out_clk_d_ff;
            if (bus.output_data_clock && !out_clk_d_ff) begin
                cap_i <= bus.i_data;
                cap_q <= bus.q_data;
            end
        end
    end
endmodule : decim_receiver

// >>> tb/decim_asserts.sv
/* Checker on the carrier between chain and receiver.
   Assumes one clock mclk and the async active-high reset rst. */
`timescale 1ns/1ps
module decim_asserts
    import decim_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] cfg_addr,
    input wire logic [DATA_W-1:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [DATA_W-1:0] cfg_rdata,
    input wire logic q_valid,
    input wire logic output_data_clock,
    input wire logic data_valid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [3:0] clk_div_ff;
    logic [3:0] quiet_ff;
    logic downconv_seen_ff;
    // Shadow of the clock-rate field and cycles since it was written
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clk_div_ff <= 4'h0;
            quiet_ff <= 4'h0;
        end else if (cfg_wr && cfg_addr == ADDR_OUTPUT_RATE) begin
            clk_div_ff <= cfg_wdata[CLKRATE_LSB +: RATE_W];
            quiet_ff <= 4'h0;
        end else if (quiet_ff != 4'hf) begin
            quiet_ff <= quiet_ff + 4'h1;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            downconv_seen_ff <= 1'b0;
        end else if (cfg_wr && cfg_addr == ADDR_POST_OPTS && cfg_wdata[OPT_DOWNCONV_BIT]) begin
            downconv_seen_ff <= 1'b1;
        end
    end
    sequence s_wr(a);
        cfg_wr && cfg_addr == a;
    endsequence
    sequence s_rd(a);
        cfg_rd && !cfg_wr && cfg_addr == a;
    endsequence
    property p_back(a);
        s_wr(a) ##2 s_rd(a) |-> cfg_rdata == $past(cfg_wdata, 2);
    endproperty
    a_reset_quiet: assert property ($fell(rst) |-> !data_valid && !q_valid && cfg_rdata == 8'h00)
        else $error("Outputs not idle after reset");
    a_rdata_idle: assert property (cfg_rdata != 8'h00 |-> cfg_rd)
        else $error("Read data outside read answer");
    a_strobe_excl: assert property (!(cfg_wr && cfg_rd))
        else $error("Write and read strobes together");
    a_unmapped_zero: assert property (s_rd(8'h10) |-> cfg_rdata == READ_ZERO)
        else $error("Unmapped read not zero");
    a_rate_back: assert property (p_back(ADDR_OUTPUT_RATE))
        else $error("Output rate register readback wrong");
    a_phase_back: assert property (p_back(ADDR_CLK_PHASE))
        else $error("Phase register readback wrong");
    a_quad_back: assert property (p_back(ADDR_QUAD))
        else $error("Quadrature select readback wrong");
    a_q_needs_mixer: assert property (q_valid |-> downconv_seen_ff)
        else $error("Quadrature output without down-conversion");
    a_clk_toggle: assert property (quiet_ff == 4'hf && clk_div_ff == 4'h0 |=>
        output_data_clock != $past(output_data_clock))
        else $error("Undivided data clock did not toggle");
endmodule : decim_asserts

// >>> tb/decimation_filter_chain_bench.sv
/* Bench for chain and receiver joined by their carrier.
   Assumes a free-running mclk and a constant sample stream. */
`timescale 1ns/1ps
module decimation_filter_chain_bench
    import decim_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic adc_valid = 1'b1;
    logic signed [SAMPLE_W-1:0] adc_data = 14'h0100;
    logic signed [SAMPLE_W-1:0] gain_offset = 14'h0020;
    logic [ADDR_W-1:0] sw_addr = 8'h00;
    logic [DATA_W-1:0] sw_wdata = 8'h00;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [DATA_W-1:0] sw_rdata;
    logic [SAMPLE_W-1:0] cap_i;
    logic [SAMPLE_W-1:0] cap_q;
    logic cap_strobe;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [7:0] d;
    int g;
    int m0;
    int m1;
    decim_if bus();
    always #4 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    decim_chain i_decim_chain (.mclk(mclk), .rst(rst), .adc_valid(adc_valid), .adc_data(adc_data),
        .gain_offset(gain_offset), .bus(bus));
    decim_receiver i_decim_receiver (.mclk(mclk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .cap_i(cap_i), .cap_q(cap_q),
        .cap_strobe(cap_strobe), .bus(bus));
    decim_asserts i_decim_asserts (.mclk(mclk), .rst(rst), .cfg_addr(bus.cfg_addr),
        .cfg_wdata(bus.cfg_wdata), .cfg_wr(bus.cfg_wr), .cfg_rd(bus.cfg_rd), .cfg_rdata(bus.cfg_rdata),
        .q_valid(bus.q_valid), .output_data_clock(bus.output_data_clock), .data_valid(bus.data_valid));
    task automatic close_out;
        if (num_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        sw_addr <= a;
        sw_wdata <= v;
        sw_wr <= 1'b1;
        @(posedge mclk);
        sw_wr <= 1'b0;
    endtask : wr
    // Answer stands in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge mclk);
        sw_rd <= 1'b0;
        #1 v = sw_rdata;
    endtask : rd
    function automatic logic seen_of(input int s);
        return s == 0 ? bus.data_valid : s == 1 ? bus.q_valid : cap_strobe;
    endfunction : seen_of
    // Cycles between two pulses of the chosen strobe
    task automatic gap_of(input int s, output int gp);
        int n;
        n = 0;
        gp = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (seen_of(s) !== 1'b1 && n < 3000);
        do begin
            @(posedge mclk);
            #1 gp++;
        end while (seen_of(s) !== 1'b1 && gp < 3000);
        if (n >= 3000 || gp >= 3000) begin
            num_errors++;
            close_out();
        end
    endtask : gap_of
    task automatic t_regs;
        rd(ADDR_PRI_LOW, d);
        chk(16'(d), 16'(RESET_VAL));
        wr(ADDR_OUTPUT_RATE, 8'h21);
        rd(ADDR_OUTPUT_RATE, d);
        chk(16'(d), 16'h0021);
        rd(ADDR_STATUS, d);
        chk(16'(d[0]), 16'h0000);
        wr(8'h10, 8'h5a);
        rd(8'h10, d);
        chk(16'(d), 16'(READ_ZERO));
        wr(ADDR_OUTPUT_RATE, 8'h00);
    endtask : t_regs
    task automatic t_gain;
        wr(ADDR_POST_OPTS, 8'h01);
        repeat (16) gap_of(0, g);
        chk(16'(bus.i_data), 16'(adc_data + gain_offset));
        chk(16'(cap_i), 16'(adc_data + gain_offset));
        chk(16'(cap_q), 16'h0000);
        wr(ADDR_POST_OPTS, 8'h00);
        repeat (16) gap_of(0, g);
        chk(16'(bus.i_data), 16'(adc_data));
    endtask : t_gain
    task automatic t_rates;
        logic [8:0] sel [4];
        int n;
        sel = '{9'h000, 9'h001, 9'h005, 9'h1ff};
        for (int k = 0; k < 4; k++) begin
            n = $countones(sel[k]);
            wr(ADDR_PRI_LOW, sel[k][7:0]);
            wr(ADDR_PRI_HIGH, {7'h00, sel[k][8]});
            wr(ADDR_OUTPUT_RATE, {4'(n), 4'(n)});
            repeat (3) gap_of(0, g);
            chk(16'(g), 16'(1 << n));
            repeat (2) gap_of(2, g);
            chk(16'(g), n == 0 ? 16'h0002 : 16'(1 << n));
        end
    endtask : t_rates
    task automatic t_ddc;
        wr(ADDR_PRI_LOW, 8'h02);
        wr(ADDR_PRI_HIGH, 8'h00);
        wr(ADDR_QUAD, 8'h01);
        rd(ADDR_QUAD, d);
        chk(16'(d), 16'h0001);
        wr(ADDR_OUTPUT_RATE, 8'h22);
        wr(ADDR_POST_OPTS, 8'h02);
        repeat (3) gap_of(0, g);
        chk(16'(g), 16'h0004);
        repeat (3) gap_of(1, g);
        chk(16'(g), 16'h0004);
        wr(ADDR_POST_OPTS, 8'h00);
    endtask : t_ddc
    // Rising-edge position of the data clock within eight cycles
    task automatic ph(input logic [7:0] p, output int m);
        wr(ADDR_CLK_PHASE, p);
        rd(ADDR_CLK_PHASE, d);
        chk(16'(d), 16'(p));
        repeat (2) gap_of(2, g);
        m = cyc % 8;
    endtask : ph
    task automatic t_phase;
        wr(ADDR_OUTPUT_RATE, 8'h33);
        ph(8'h00, m0);
        ph(8'h0c, m1);
        chk(16'((m1 - m0 + 8) % 8), 16'h0004);
        ph(8'h04, m1);
        chk(16'(m1), 16'(m0));
        wr(ADDR_OUTPUT_RATE, 8'h11);
        ph(8'h08, m0);
        ph(8'h0c, m1);
        chk(16'(m1 % 2), 16'(m0 % 2));
        wr(ADDR_OUTPUT_RATE, 8'h00);
        ph(8'h0c, m1);
        repeat (12) gap_of(2, g);
        chk(16'(g), 16'h0002);
    endtask : t_phase
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_gain();
        t_rates();
        t_ddc();
        t_phase();
        close_out();
    end
endmodule : decimation_filter_chain_bench
